// ===== hdl/pwd_consts.vh
// constants for the power-on reset and watchdog block
`ifndef PWD_CONSTS_VH
`define PWD_CONSTS_VH

// register word indices (word index in byte address bits 4:2)
`define PWD_ADDR_CTRL     3'h0
`define PWD_ADDR_SERVICE  3'h1
`define PWD_ADDR_STATUS   3'h2
`define PWD_ADDR_IRQ_STAT 3'h3
`define PWD_ADDR_IRQ_MASK 3'h4
`define PWD_ADDR_COUNT    3'h5

// control register fields
`define PWD_CTRL_RATE_LO  0
`define PWD_CTRL_RATE_HI  1
`define PWD_CTRL_RESET_DISABLE_BIT     2

// status register fields
`define PWD_ST_ENABLED    0
`define PWD_ST_ARMED      1
`define PWD_ST_CAUSE_WD   2
`define PWD_ST_SPECIAL    3
`define PWD_ST_RATE_LOCK  4

// interrupt event bits
`define PWD_EV_SERVICED   0
`define PWD_EV_RATE_REJ   1
`define PWD_EV_BAD_KEY    2
`define PWD_EV_WIDTH      3

// service keys
`define PWD_KEY_ARM       8'h55
`define PWD_KEY_CLEAR     8'haa

// timing counts in e clock cycles
`define PWD_POR_CYCLES    12'hfe0
`define PWD_DRIVE_CYCLES  3'h4
`define PWD_SAMPLE_DELAY  3'h2
`define PWD_RATE_WINDOW   7'h40
`define PWD_PRESCALE_LOG2 15

// rate factors 1, 4, 16, 64
`define PWD_FACT_0        7'h01
`define PWD_FACT_1        7'h04
`define PWD_FACT_2        7'h10
`define PWD_FACT_3        7'h40

`endif

// ===== hdl/pwd_watchdog.v
// power-on reset timer, software watchdog and reset pin sequencer
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "pwd_consts.vh"
module pwd_watchdog #(
  parameter PRESCALE_LOG2 = `PWD_PRESCALE_LOG2
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [4:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output wire        avs_waitrequest_o,
  input  wire        watchdog_disable_bit_i,
  input  wire        special_mode_i,
  input  wire        reset_pin_i,
  output wire        reset_pin_o,
  output wire        reset_pin_oe_o,
  output wire        sys_reset_o,
  output reg         cause_watchdog_o,
  output wire        irq_o
);

  // ****************************************
  // reset sequencer states
  // ****************************************
  localparam [4:0] ST_POR   = 5'h01;
  localparam [4:0] ST_RUN   = 5'h02;
  localparam [4:0] ST_DRIVE = 5'h04;
  localparam [4:0] ST_WAIT  = 5'h08;
  localparam [4:0] ST_HOLD  = 5'h10;

  reg  [4:0]               state;
  reg  [11:0]              por_cnt;
  reg  [2:0]               seq_cnt;
  reg                      cause_pending;
  reg                      wd_enabled;
  reg                      special;
  reg  [PRESCALE_LOG2-1:0] prescale;
  reg  [6:0]               wd_cnt;
  reg                      armed;
  reg  [1:0]               rate;
  reg                      rate_lock;
  reg  [6:0]               win_cnt;
  reg                      reset_disable_bit;
  reg  [`PWD_EV_WIDTH-1:0] irq_stat;
  reg  [`PWD_EV_WIDTH-1:0] irq_mask;
  reg                      ack;
  reg  [6:0]               factor;
  reg  [31:0]              next_readdata;
  reg  [`PWD_EV_WIDTH-1:0] ev;

  wire       in_reset  = (state != ST_RUN);
  wire       pre_tick  = &prescale;
  wire [2:0] reg_sel   = avs_address_i[4:2];
  wire       wr_go     = avs_write_i & ~ack & ~in_reset;
  wire       rd_go     = avs_read_i & ~ack;
  wire       wr_ctrl   = wr_go & (reg_sel == `PWD_ADDR_CTRL)
                         & avs_byteenable_i[0];
  wire       wr_serv   = wr_go & (reg_sel == `PWD_ADDR_SERVICE)
                         & avs_byteenable_i[0];
  wire [7:0] wkey      = avs_writedata_i[7:0];
  wire       serviced  = wr_serv & armed & (wkey == `PWD_KEY_CLEAR);
  wire       rate_ok   = special
                         | (~rate_lock & (win_cnt < `PWD_RATE_WINDOW));
  // fires one tick after factor ticks
  wire       timeout   = pre_tick & (wd_cnt == factor);
  wire       wd_reset  = timeout & wd_enabled & ~reset_disable_bit;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign reset_pin_o       = 1'b0;
  assign reset_pin_oe_o    = (state == ST_POR) | (state == ST_DRIVE);
  assign sys_reset_o       = in_reset;
  assign irq_o             = |(irq_stat & irq_mask);

  // ****************************************
  // rate factor decode
  // ****************************************
  always @* begin
    case (rate)
      2'b00:   factor = `PWD_FACT_0;
      2'b01:   factor = `PWD_FACT_1;
      2'b10:   factor = `PWD_FACT_2;
      2'b11:   factor = `PWD_FACT_3;
      default: factor = `PWD_FACT_0;
    endcase
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state            <= ST_POR;
      por_cnt          <= 12'h000;
      seq_cnt          <= 3'h0;
      cause_pending    <= 1'b0;
      cause_watchdog_o <= 1'b0;
      wd_enabled       <= 1'b0;
      special          <= 1'b0;
    end else begin
      case (state)
        ST_POR: begin
          if (por_cnt == `PWD_POR_CYCLES - 12'h001) begin
            state <= ST_HOLD;
          end else begin
            por_cnt <= por_cnt + 12'h001;
          end
        end
        ST_RUN: begin
          seq_cnt <= 3'h0;
          if (wd_reset) begin
            cause_pending <= 1'b1;
            state         <= ST_DRIVE;
          end else if (!reset_pin_i) begin
            cause_pending <= 1'b0;
            state         <= ST_DRIVE;
          end
        end
        ST_DRIVE: begin
          if (seq_cnt == `PWD_DRIVE_CYCLES - 3'h1) begin
            seq_cnt <= 3'h0;
            state   <= ST_WAIT;
          end else begin
            seq_cnt <= seq_cnt + 3'h1;
          end
        end
        ST_WAIT: begin
          if (seq_cnt == `PWD_SAMPLE_DELAY - 3'h1) begin
            if (!reset_pin_i) begin
              cause_pending <= 1'b0;
            end
            state <= ST_HOLD;
          end else begin
            seq_cnt <= seq_cnt + 3'h1;
          end
        end
        ST_HOLD: begin
          if (reset_pin_i) begin
            state            <= ST_RUN;
            cause_watchdog_o <= cause_pending;
            // later changes wait for next reset
            wd_enabled       <= ~watchdog_disable_bit_i;
            special          <= special_mode_i;
          end
        end
        default: state <= ST_POR;
      endcase
    end
  end

  // ****************************************
  // prescaler and watchdog divider
  // ****************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prescale <= {PRESCALE_LOG2{1'b0}};
    end else begin
      prescale <= prescale + {{(PRESCALE_LOG2-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_cnt <= 7'h00;
      armed  <= 1'b0;
    end else if (in_reset) begin
      wd_cnt <= 7'h00;
      armed  <= 1'b0;
    end else begin
      if (serviced || timeout) begin
        wd_cnt <= 7'h00;
      end else if (pre_tick) begin
        wd_cnt <= wd_cnt + 7'h01;
      end
      if (wr_serv) begin
        armed <= (wkey == `PWD_KEY_ARM);
      end
    end
  end

  // ****************************************
  // control register
  // ****************************************
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rate      <= 2'b00;
      rate_lock <= 1'b0;
      win_cnt   <= 7'h00;
      reset_disable_bit      <= 1'b0;
    end else if (in_reset) begin
      rate      <= 2'b00;
      rate_lock <= 1'b0;
      win_cnt   <= 7'h00;
      // inhibited at start in special modes
      reset_disable_bit      <= special_mode_i;
    end else begin
      if (win_cnt < `PWD_RATE_WINDOW) begin
        win_cnt <= win_cnt + 7'h01;
      end
      if (wr_ctrl) begin
        if (rate_ok) begin
          rate      <= {avs_writedata_i[`PWD_CTRL_RATE_HI],
                        avs_writedata_i[`PWD_CTRL_RATE_LO]};
          rate_lock <= 1'b1;
        end
        reset_disable_bit <= special & avs_writedata_i[`PWD_CTRL_RESET_DISABLE_BIT];
      end
      if (!special) begin
        reset_disable_bit <= 1'b0;
      end
    end
  end

  // ****************************************
  // interrupt registers
  // ****************************************
  always @* begin
    ev = {`PWD_EV_WIDTH{1'b0}};
    ev[`PWD_EV_SERVICED] = serviced;
    ev[`PWD_EV_RATE_REJ] = wr_ctrl & ~rate_ok;
    ev[`PWD_EV_BAD_KEY]  = wr_serv & (wkey != `PWD_KEY_ARM)
                           & ~serviced;
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= {`PWD_EV_WIDTH{1'b0}};
      irq_mask <= {`PWD_EV_WIDTH{1'b0}};
    end else begin
      // set wins over write-one-to-clear
      if (wr_go && reg_sel == `PWD_ADDR_IRQ_STAT && avs_byteenable_i[0]) begin
        irq_stat <= (irq_stat & ~avs_writedata_i[`PWD_EV_WIDTH-1:0]) | ev;
      end else begin
        irq_stat <= irq_stat | ev;
      end
      if (wr_go && reg_sel == `PWD_ADDR_IRQ_MASK && avs_byteenable_i[0]) begin
        irq_mask <= avs_writedata_i[`PWD_EV_WIDTH-1:0];
      end
    end
  end

  // ****************************************
  // avalon slave
  // ****************************************
  always @* begin
    next_readdata = 32'h0000_0000;
    case (reg_sel)
      `PWD_ADDR_CTRL: begin
        next_readdata[`PWD_CTRL_RATE_LO] = rate[0];
        next_readdata[`PWD_CTRL_RATE_HI] = rate[1];
        next_readdata[`PWD_CTRL_RESET_DISABLE_BIT]    = reset_disable_bit;
      end
      `PWD_ADDR_STATUS: begin
        next_readdata[`PWD_ST_ENABLED]   = wd_enabled;
        next_readdata[`PWD_ST_ARMED]     = armed;
        next_readdata[`PWD_ST_CAUSE_WD]  = cause_watchdog_o;
        next_readdata[`PWD_ST_SPECIAL]   = special;
        next_readdata[`PWD_ST_RATE_LOCK] = rate_lock;
      end
      `PWD_ADDR_IRQ_STAT: next_readdata[`PWD_EV_WIDTH-1:0] = irq_stat;
      `PWD_ADDR_IRQ_MASK: next_readdata[`PWD_EV_WIDTH-1:0] = irq_mask;
      `PWD_ADDR_COUNT:    next_readdata[6:0] = wd_cnt;
      default:            next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
      if (rd_go) begin
        avs_readdata_o <= next_readdata;
      end
    end
  end

endmodule // pwd_watchdog

// ===== tb/pwd_watchdog_asserts.sv
// checker for the power-on reset and watchdog block
`timescale 1ns/10ps
module pwd_watchdog_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic reset_pin_i,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe_o,
  input wire logic sys_reset_o,
  input wire logic cause_watchdog_o
);
  // *****
  // pin drive length counter
  // *****
  logic [12:0] hi_cnt;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i) hi_cnt <= 13'h0;
    else if (reset_pin_oe_o) hi_cnt <= hi_cnt + 13'h1;
    else hi_cnt <= 13'h0;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_one_wait_a: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o) else $error("bus answer late");
  drive_len_a: assert property ($fell(reset_pin_oe_o) |->
    hi_cnt == 13'h4 || hi_cnt == 13'hfe0) else $error("bad drive length");
  drive_in_reset_a: assert property (
    reset_pin_oe_o |-> sys_reset_o) else $error("drive outside reset");
  pin_low_a: assert property (
    reset_pin_oe_o |-> !reset_pin_o) else $error("pin not driven low");
  ext_trig_a: assert property (
    !sys_reset_o && !reset_pin_i |=> reset_pin_oe_o) else $error("no drive");
  drive_from_run_a: assert property (
    $rose(reset_pin_oe_o) |-> !$past(sys_reset_o)) else $error("drive start");
  sample_hold_a: assert property (
    $fell(reset_pin_oe_o) && hi_cnt == 13'h4 |-> sys_reset_o[*3])
    else $error("left reset before sample");
  cause_hold_a: assert property (
    !sys_reset_o && !$past(sys_reset_o) |-> $stable(cause_watchdog_o))
    else $error("cause changed in run");
  cover property ($fell(reset_pin_oe_o) && hi_cnt == 13'h4);
  cover property ($rose(cause_watchdog_o));
  cover property (!sys_reset_o && !reset_pin_i);
endmodule // pwd_watchdog_asserts
bind pwd_watchdog pwd_watchdog_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_waitrequest_o(avs_waitrequest_o), .reset_pin_i(reset_pin_i),
  .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
  .sys_reset_o(sys_reset_o), .cause_watchdog_o(cause_watchdog_o));

// ===== tb/pwd_watchdog_test.sv
// testbench for the power-on reset and watchdog block
`timescale 1ns/10ps
`include "pwd_consts.vh"
module pwd_watchdog_test;
  logic        clk_i, rst_i, rd, wr, dis, spec, ext_low, bad;
  logic [4:0]  adr;
  logic [7:0]  key;
  logic [31:0] wdat, rdata, seed, k;
  logic [31:0] rdo;
  wire         wreq, pin_o, oe, sys_rst, cause, irq;
  wire         pin = ~(oe | ext_low);
  int          n_fail, num_checks, n;
  pwd_watchdog #(.PRESCALE_LOG2(4)) u_pwd_watchdog (.clk_i(clk_i),
    .rst_i(rst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wreq), .watchdog_disable_bit_i(dis),
    .special_mode_i(spec), .reset_pin_i(pin), .reset_pin_o(pin_o),
    .reset_pin_oe_o(oe), .sys_reset_o(sys_rst), .cause_watchdog_o(cause),
    .irq_o(irq));
  // *****
  // helpers
  // *****
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task test_done();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task bus(logic w, logic [2:0] r, logic [31:0] d);
    int   c;
    logic stall;
    c = 0;
    stall = 1'b1;
    @(posedge clk_i);
    adr <= {r, 2'b00};
    wdat <= d;
    wr <= w;
    rd <= !w;
    // values settled mid-cycle are those standing at the next rising edge
    do begin
      @(negedge clk_i);
      c++;
      stall = wreq;
      rdata = rdo;
      @(posedge clk_i);
    end while (stall !== 1'b0 && c < 20);
    if (stall !== 1'b0) begin
      n_fail++;
      test_done();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task wt(int lim, logic s, logic v, logic must);
    n = 0;
    while ((s ? sys_rst : oe) !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    if (must && n >= lim) begin
      n_fail++;
      test_done();
    end
  endtask
  task svc();
    bus(1, `PWD_ADDR_SERVICE, 32'h55);
    bus(1, `PWD_ADDR_SERVICE, 32'haa);
  endtask
  task boot(logic d, logic sp);
    @(posedge clk_i);
    rst_i <= 1'b1;
    dis <= d;
    spec <= sp;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    wt(5000, 0, 0, 1);
    chk("por_len", 1, n > 4060 && n < 4068);
    wt(10, 1, 0, 1);
  endtask
  initial begin
    clk_i = 0;
    forever #25 clk_i = ~clk_i;
  end
  // *****
  // scenarios
  // *****
  initial begin
    {rd, wr, dis, spec, ext_low, adr, wdat} = '0;
    rst_i = 1'b1;
    seed = 32'h45;
    boot(0, 0);
    bus(1, `PWD_ADDR_CTRL, 32'h5);
    svc();
    bus(0, `PWD_ADDR_CTRL, 0);
    chk("ctrl", 32'h1, rdata & 32'h7);
    bus(0, `PWD_ADDR_STATUS, 0);
    chk("status", 32'h1, rdata & 32'h9);
    bus(0, `PWD_ADDR_IRQ_STAT, 0);
    chk("serviced", 32'h1, rdata & 32'h7);
    bus(1, `PWD_ADDR_CTRL, 32'h3);
    bus(0, `PWD_ADDR_CTRL, 0);
    chk("rate_lock", 32'h1, rdata & 32'h7);
    bus(1, `PWD_ADDR_IRQ_MASK, 32'h2);
    chk("irq_on", 1, irq);
    bus(1, `PWD_ADDR_IRQ_MASK, 32'h0);
    chk("irq_mask", 0, irq);
    bus(1, `PWD_ADDR_IRQ_MASK, 32'h2);
    bus(1, `PWD_ADDR_IRQ_STAT, 32'h7);
    chk("irq_clr", 0, irq);
    svc();
    for (int i = 0; i < 6; i++) begin
      k = rnd();
      bad = (i < 2) ? i[0] : k[0];
      key = (k[15:8] == 8'h55 || k[15:8] == 8'haa) ? 8'h12 : k[15:8];
      bus(1, `PWD_ADDR_SERVICE, 32'h55);
      repeat (k[3:2]) begin
        bus(0, `PWD_ADDR_STATUS, 0);
        chk("armed", 1, rdata[1]);
      end
      if (bad) bus(1, `PWD_ADDR_SERVICE, {24'h0, key});
      bus(1, `PWD_ADDR_SERVICE, 32'haa);
      bus(0, `PWD_ADDR_IRQ_STAT, 0);
      chk("svc_event", bad ? 32'h4 : 32'h1, rdata & 32'h7);
      if (bad) svc();
      bus(1, `PWD_ADDR_IRQ_STAT, 32'h7);
    end
    dis <= 1'b1;
    svc();
    bus(1, `PWD_ADDR_SERVICE, 32'h55);
    wt(200, 0, 1, 1);
    chk("timeout", 1, n >= 60 && n <= 84);
    wt(20, 1, 0, 1);
    chk("cause", 1, cause);
    bus(0, `PWD_ADDR_STATUS, 0);
    chk("cause_bit", 32'h4, rdata & 32'h7);
    bus(0, `PWD_ADDR_CTRL, 0);
    chk("ctrl_rst", 0, rdata & 32'h7);
    wt(200, 0, 1, 0);
    chk("disabled", 200, n);
    @(posedge clk_i);
    dis <= 1'b0;
    ext_low <= 1'b1;
    repeat (10) @(posedge clk_i);
    ext_low <= 1'b0;
    wt(20, 1, 0, 1);
    chk("cause_ext", 0, cause);
    boot(0, 1);
    bus(0, `PWD_ADDR_CTRL, 0);
    chk("reset_disable_bit_special", 32'h4, rdata & 32'h7);
    wt(150, 0, 1, 0);
    chk("inhibit", 150, n);
    bus(1, `PWD_ADDR_CTRL, 32'h0);
    wt(100, 0, 1, 1);
    chk("reenabled", 1, oe);
    test_done();
  end
endmodule // pwd_watchdog_test
